//--- design/ssmp_defines.svh
// Constants of the message-pipe slave: opcodes, config fields, frame bytes.
// Assumes inclusion by bare name from the design file.
`ifndef SSMP_DEFINES_SVH
`define SSMP_DEFINES_SVH

// ==========================================================================
// Opcodes
`define SSMP_OP_READ_PROTOCOL_RECORD 8'h01
`define SSMP_OP_WRITE_PROTOCOL_SETUP 8'h02
`define SSMP_OP_COMMAND_CHANNEL      8'h03
`define SSMP_OP_CHANNEL_SIZES_READ   8'h04
`define SSMP_OP_RESPONSE_CHANNEL     8'h05
`define SSMP_OP_SAMPLE_CHANNEL       8'h06

// ==========================================================================
// Data-ready configuration fields
`define SSMP_CFG_MEAS_WAIT_POS  3
`define SSMP_CFG_NOTIF_WAIT_POS 2
`define SSMP_CFG_DRIVE_POS      1
`define SSMP_CFG_IDLE_POS       0
`define SSMP_CFG_RESET          4'hC

// ==========================================================================
// Frame and transfer bytes
`define SSMP_FIRST_TX_BYTE   8'hFA
`define SSMP_FILL_BYTE       8'hFF
`define SSMP_NO_DATA_BYTE    8'hFF
`define SSMP_FRAME_TARGET    8'hFF
`define SSMP_HEADER_BYTES    16'h0004
`define SSMP_MIN_FRAME_BYTES 16'h0003

`endif

//--- design/ssmp_pkg.sv
// Types shared by the message-pipe slave.
// Assumes nothing of its surroundings.
package ssmp_pkg;

  // ========================================================================
  // Types
  typedef logic [7:0]  ssmp_byte_t;
  typedef logic [15:0] ssmp_count_t;
  typedef logic [3:0]  ssmp_cfg_t;

  typedef enum logic {
    SSMP_IDLE,
    SSMP_ACTIVE
  } ssmp_xfer_t;

endpackage

//--- design/ssmp_message_pipes.sv
// Slave message-pipe protocol layer over an SPI mode 3 transport.
// Assumes the link pins are asynchronous to clk and toggle at most once
// per four clk cycles; user-side ports are synchronous to clk.
//
// Operation
// - Device only answers transfers the host starts.
// - One transfer carries exactly one framed message.
// - Commands stream out; responses load notification pipe.
// - Mode messages switch setup and sampling operation.
// - Sampling messages load measurement pipe in sampling.
// - First byte is opcode, selects transfer kind.
// - Pipe frames omit preamble and target byte.
// - Checksum includes omitted target byte as 0xFF.
// - Protocol record returns version then config byte.
// - Setup opcode byte becomes active config.
// - Command opcode carries one reduced frame.
// - Sizes read returns two little-endian counts.
// - Response opcode returns one notification frame.
// - Sample opcode returns one measurement frame.
// - Line active while either pipe holds message and its wait flag is set.
// - Line idles once all pending messages read.
// - Config bit 3 gates measurement wait flag.
// - Config bit 2 gates notification wait flag.
// - Config bit 1 selects push-pull or open-drain.
// - Config bit 0 selects idle level.
// - Config bits 7:4 reserved, read zero.
`timescale 1ns/1ps
`include "ssmp_defines.svh"

module ssmp_message_pipes #(
  parameter int         MSG_DEPTH        = 512,
  parameter logic [7:0] PROTOCOL_VERSION = 8'h01,
  parameter logic [7:0] ENTER_SETUP_MID  = 8'h30,
  parameter logic [7:0] ENTER_SAMPLE_MID = 8'h10
) (
  input  logic               clk,
  input  logic               reset_n,
  input  logic               ce,
  input  logic               spi_cs_n,
  input  logic               spi_sck,
  input  logic               spi_mosi,
  output logic               spi_miso,
  output logic               spi_miso_oe,
  output logic               cmd_valid,
  output ssmp_pkg::ssmp_byte_t cmd_byte,
  output logic               cmd_end,
  output logic               cmd_ok,
  output logic               sampling_mode,
  input  logic               notif_wr_valid,
  input  ssmp_pkg::ssmp_byte_t notif_wr_byte,
  input  logic               notif_wr_last,
  output logic               notif_wr_ready,
  input  logic               meas_wr_valid,
  input  ssmp_pkg::ssmp_byte_t meas_wr_byte,
  input  logic               meas_wr_last,
  output logic               meas_wr_ready,
  output logic               message_waiting_line,
  output logic               message_waiting_line_oe
);
  import ssmp_pkg::*;

  localparam int AW = (MSG_DEPTH > 1) ? $clog2(MSG_DEPTH) : 1;
  localparam ssmp_count_t DEPTH_C = ssmp_count_t'(MSG_DEPTH);

  if (MSG_DEPTH < 4 || MSG_DEPTH > 65535) begin : g_bad_depth
    $error("MSG_DEPTH must lie between 4 and 65535");
  end

  // ========================================================================
  // Link input synchronisers
  logic [2:0] cs_sync;
  logic [2:0] sck_sync;
  logic [1:0] mosi_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync   <= 3'h7;
      sck_sync  <= 3'h7;
      mosi_sync <= 2'h0;
    end else if (ce) begin
      cs_sync   <= {cs_sync[1:0], spi_cs_n};
      sck_sync  <= {sck_sync[1:0], spi_sck};
      mosi_sync <= {mosi_sync[0], spi_mosi};
    end
  end

  logic sck_rise, sck_fall, cs_fall, cs_rise, mosi_bit;

  assign sck_rise = sck_sync[1] & ~sck_sync[2];
  assign sck_fall = ~sck_sync[1] & sck_sync[2];
  assign cs_fall  = ~cs_sync[1] & cs_sync[2];
  assign cs_rise  = cs_sync[1] & ~cs_sync[2];
  assign mosi_bit = mosi_sync[1];

  // ========================================================================
  // Message pipes: index 0 notification, index 1 measurement
  logic        pipe_full[2], pipe_consume[2], pipe_wr_valid[2], pipe_wr_last[2], pipe_wr_allow[2];
  ssmp_count_t pipe_size[2], rd_ptr;
  ssmp_byte_t  pipe_rdata[2], pipe_wr_byte[2];

  assign pipe_wr_valid[0] = notif_wr_valid;
  assign pipe_wr_byte[0]  = notif_wr_byte;
  assign pipe_wr_last[0]  = notif_wr_last;
  assign pipe_wr_allow[0] = 1'b1;
  assign pipe_wr_valid[1] = meas_wr_valid;
  assign pipe_wr_byte[1]  = meas_wr_byte;
  assign pipe_wr_last[1]  = meas_wr_last;
  assign pipe_wr_allow[1] = sampling_mode;

  assign notif_wr_ready = ~pipe_full[0] & pipe_wr_allow[0] & ce;
  assign meas_wr_ready  = ~pipe_full[1] & pipe_wr_allow[1] & ce;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pipe
      ssmp_byte_t  mem [MSG_DEPTH];
      ssmp_count_t wptr, next_wptr, next_size;
      logic        next_full, take, room;

      assign take = pipe_wr_valid[g] & ~pipe_full[g] & pipe_wr_allow[g];
      assign room = (wptr < DEPTH_C);

      always_comb begin
        next_wptr = wptr;
        next_size = pipe_size[g];
        next_full = pipe_full[g];
        if (pipe_consume[g]) begin
          next_full = 1'b0;
          next_size = 16'h0000;
        end else if (take) begin
          next_wptr = room ? 16'(wptr + 16'h0001) : wptr;
          if (pipe_wr_last[g]) begin
            next_full = 1'b1;
            next_size = room ? 16'(wptr + 16'h0001) : wptr;
            next_wptr = 16'h0000;
          end
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          wptr         <= 16'h0000;
          pipe_size[g] <= 16'h0000;
          pipe_full[g] <= 1'b0;
        end else if (ce) begin
          wptr         <= next_wptr;
          pipe_size[g] <= next_size;
          pipe_full[g] <= next_full;
        end
      end

      always_ff @(posedge clk) begin
        if (ce && take && room) begin
          mem[wptr[AW-1:0]] <= pipe_wr_byte[g];
        end
      end

      assign pipe_rdata[g] = mem[rd_ptr[AW-1:0]];
    end
  endgenerate

  // ========================================================================
  // Transfer engine
  ssmp_xfer_t  xfer, next_xfer;
  logic [2:0]  bit_cnt, next_bit_cnt;
  ssmp_byte_t  rx_shift, next_rx_shift, tx_shift, next_tx_shift;
  ssmp_byte_t  opcode, next_opcode, chk, next_chk, first_mid, next_first_mid, next_cmd_byte;
  ssmp_count_t byte_idx, next_byte_idx, cmd_cnt, next_cmd_cnt, next_rd_ptr;
  ssmp_cfg_t   cfg, next_cfg;
  logic        next_miso, next_sampling_mode, next_cmd_valid, next_cmd_end, next_cmd_ok;
  logic        next_line, next_line_oe;

  ssmp_byte_t  rx_byte, tx_byte;
  ssmp_count_t tx_idx, data_idx;
  logic        pipe_sel, pipe_op, waiting, level;

  assign rx_byte  = {rx_shift[6:0], mosi_bit};
  assign tx_idx   = 16'(byte_idx + 16'h0001);
  assign data_idx = 16'(tx_idx - `SSMP_HEADER_BYTES);
  assign pipe_sel = (opcode == `SSMP_OP_SAMPLE_CHANNEL);
  assign pipe_op  = (opcode == `SSMP_OP_RESPONSE_CHANNEL) | pipe_sel;

  // Byte to send in the slot after the one now completing
  always_comb begin
    tx_byte = `SSMP_NO_DATA_BYTE;
    if (tx_idx < `SSMP_HEADER_BYTES) begin
      tx_byte = `SSMP_FILL_BYTE;
    end else begin
      case (opcode)
        `SSMP_OP_READ_PROTOCOL_RECORD: begin
          tx_byte = data_idx[0] ? {4'h0, cfg} : PROTOCOL_VERSION;
        end
        `SSMP_OP_CHANNEL_SIZES_READ: begin
          case (data_idx[1:0])
            2'h0:    tx_byte = pipe_size[0][7:0];
            2'h1:    tx_byte = pipe_size[0][15:8];
            2'h2:    tx_byte = pipe_size[1][7:0];
            default: tx_byte = pipe_size[1][15:8];
          endcase
        end
        `SSMP_OP_RESPONSE_CHANNEL,
        `SSMP_OP_SAMPLE_CHANNEL: begin
          if (pipe_full[pipe_sel]) begin
            tx_byte = pipe_rdata[pipe_sel];
          end
        end
        default: tx_byte = `SSMP_NO_DATA_BYTE;
      endcase
    end
  end

  assign waiting = (pipe_full[0] & cfg[`SSMP_CFG_NOTIF_WAIT_POS])
                 | (pipe_full[1] & cfg[`SSMP_CFG_MEAS_WAIT_POS]);
  assign level   = waiting ^ cfg[`SSMP_CFG_IDLE_POS];

  always_comb begin
    next_xfer          = xfer;
    next_bit_cnt       = bit_cnt;
    next_rx_shift      = rx_shift;
    next_tx_shift      = tx_shift;
    next_miso          = spi_miso;
    next_byte_idx      = byte_idx;
    next_opcode        = opcode;
    next_chk           = chk;
    next_first_mid     = first_mid;
    next_cmd_cnt       = cmd_cnt;
    next_rd_ptr        = rd_ptr;
    next_cfg           = cfg;
    next_sampling_mode = sampling_mode;
    next_cmd_valid     = 1'b0;
    next_cmd_byte      = cmd_byte;
    next_cmd_end       = 1'b0;
    next_cmd_ok        = cmd_ok;
    pipe_consume[0]    = 1'b0;
    pipe_consume[1]    = 1'b0;
    next_line          = cfg[`SSMP_CFG_DRIVE_POS] ? 1'b0 : level;
    next_line_oe       = cfg[`SSMP_CFG_DRIVE_POS] ? ~level : 1'b1;
    case (xfer)
      SSMP_IDLE: begin
        if (cs_fall) begin
          next_xfer      = SSMP_ACTIVE;
          next_bit_cnt   = 3'h0;
          next_byte_idx  = 16'h0000;
          next_opcode    = 8'h00;
          next_tx_shift  = `SSMP_FIRST_TX_BYTE;
          next_chk       = `SSMP_FRAME_TARGET;
          next_first_mid = 8'h00;
          next_cmd_cnt   = 16'h0000;
          next_rd_ptr    = 16'h0000;
        end
      end
      SSMP_ACTIVE: begin
        if (cs_rise) begin
          next_xfer = SSMP_IDLE;
          if (opcode == `SSMP_OP_COMMAND_CHANNEL && cmd_cnt != 16'h0000) begin
            next_cmd_end = 1'b1;
            next_cmd_ok  = (chk == 8'h00) && (cmd_cnt >= `SSMP_MIN_FRAME_BYTES);
            if (next_cmd_ok && first_mid == ENTER_SAMPLE_MID) begin
              next_sampling_mode = 1'b1;
            end else if (next_cmd_ok && first_mid == ENTER_SETUP_MID) begin
              next_sampling_mode = 1'b0;
            end
          end
          if (pipe_op && pipe_full[pipe_sel] &&
              byte_idx >= 16'(pipe_size[pipe_sel] + `SSMP_HEADER_BYTES)) begin
            pipe_consume[pipe_sel] = 1'b1;
          end
        end else begin
          if (sck_fall) begin
            next_miso     = tx_shift[7];
            next_tx_shift = {tx_shift[6:0], 1'b1};
          end
          if (sck_rise) begin
            next_rx_shift = rx_byte;
            next_bit_cnt  = 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
              if (byte_idx != 16'hFFFF) begin
                next_byte_idx = tx_idx;
              end
              if (byte_idx == 16'h0000) begin
                next_opcode = rx_byte;
              end else if (byte_idx >= `SSMP_HEADER_BYTES) begin
                case (opcode)
                  `SSMP_OP_WRITE_PROTOCOL_SETUP: begin
                    if (byte_idx == `SSMP_HEADER_BYTES) begin
                      next_cfg = rx_byte[3:0];
                    end
                  end
                  `SSMP_OP_COMMAND_CHANNEL: begin
                    next_cmd_valid = 1'b1;
                    next_cmd_byte  = rx_byte;
                    next_chk       = 8'(chk + rx_byte);
                    if (cmd_cnt == 16'h0000) begin
                      next_first_mid = rx_byte;
                    end
                    if (cmd_cnt != 16'hFFFF) begin
                      next_cmd_cnt = 16'(cmd_cnt + 16'h0001);
                    end
                  end
                  default: begin
                  end
                endcase
              end
              next_tx_shift = tx_byte;
              if (tx_idx >= `SSMP_HEADER_BYTES && pipe_op && pipe_full[pipe_sel]) begin
                if (16'(rd_ptr + 16'h0001) >= pipe_size[pipe_sel]) begin
                  next_rd_ptr = 16'h0000;
                end else begin
                  next_rd_ptr = 16'(rd_ptr + 16'h0001);
                end
              end
            end
          end
        end
      end
      default: next_xfer = SSMP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer                    <= SSMP_IDLE;
      bit_cnt                 <= 3'h0;
      rx_shift                <= 8'h00;
      tx_shift                <= 8'hFF;
      spi_miso                <= 1'b1;
      byte_idx                <= 16'h0000;
      opcode                  <= 8'h00;
      chk                     <= 8'h00;
      first_mid               <= 8'h00;
      cmd_cnt                 <= 16'h0000;
      rd_ptr                  <= 16'h0000;
      cfg                     <= `SSMP_CFG_RESET;
      sampling_mode           <= 1'b0;
      cmd_valid               <= 1'b0;
      cmd_byte                <= 8'h00;
      cmd_end                 <= 1'b0;
      cmd_ok                  <= 1'b0;
      message_waiting_line    <= 1'b0;
      message_waiting_line_oe <= 1'b1;
    end else if (ce) begin
      xfer                    <= next_xfer;
      bit_cnt                 <= next_bit_cnt;
      rx_shift                <= next_rx_shift;
      tx_shift                <= next_tx_shift;
      spi_miso                <= next_miso;
      byte_idx                <= next_byte_idx;
      opcode                  <= next_opcode;
      chk                     <= next_chk;
      first_mid               <= next_first_mid;
      cmd_cnt                 <= next_cmd_cnt;
      rd_ptr                  <= next_rd_ptr;
      cfg                     <= next_cfg;
      sampling_mode           <= next_sampling_mode;
      cmd_valid               <= next_cmd_valid;
      cmd_byte                <= next_cmd_byte;
      cmd_end                 <= next_cmd_end;
      cmd_ok                  <= next_cmd_ok;
      message_waiting_line    <= next_line;
      message_waiting_line_oe <= next_line_oe;
    end
  end

  assign spi_miso_oe = (xfer == SSMP_ACTIVE);

endmodule

//--- tb/ssmp_message_pipes_props.sv
// Checker of the message-pipe slave, bound to the design top.
// Assumes it sees only the top-level ports of the design.
`timescale 1ns/1ps
module ssmp_message_pipes_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic cmd_valid,
  input wire logic cmd_end,
  input wire logic cmd_ok,
  input wire logic sampling_mode,
  input wire logic notif_wr_valid,
  input wire logic notif_wr_last,
  input wire logic notif_wr_ready,
  input wire logic meas_wr_valid,
  input wire logic meas_wr_last,
  input wire logic meas_wr_ready,
  input wire logic message_waiting_line,
  input wire logic message_waiting_line_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Sequences
  sequence s_notif_last;
    notif_wr_valid && notif_wr_last && notif_wr_ready;
  endsequence
  sequence s_meas_last;
    meas_wr_valid && meas_wr_last && meas_wr_ready;
  endsequence
  sequence s_cmd_good;
    cmd_end && cmd_ok;
  endsequence

  // ==========================================================================
  // Assertions
  chk_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid wider than one cycle");
  chk_end_pulse: assert property (cmd_end |=> !cmd_end)
    else $error("cmd_end wider than one cycle");
  chk_end_after_cs: assert property (cmd_end |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("cmd_end before transfer closed");
  chk_mode_cause: assert property ($changed(sampling_mode) |-> s_cmd_good)
    else $error("mode changed without good command");
  chk_meas_gate: assert property (!sampling_mode |-> !meas_wr_ready)
    else $error("measurement pipe open in setup");
  chk_oe_release: assert property (spi_cs_n [*8] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  chk_oe_active: assert property (!spi_cs_n [*8] |-> spi_miso_oe)
    else $error("miso not driven in transfer");
  chk_od_output: assert property (message_waiting_line |-> message_waiting_line_oe)
    else $error("line high without drive");
  chk_notif_full: assert property (s_notif_last |=> !notif_wr_ready)
    else $error("notification pipe open after message");
  chk_meas_full: assert property (s_meas_last |=> !meas_wr_ready)
    else $error("measurement pipe open after message");
endmodule

bind ssmp_message_pipes ssmp_message_pipes_props ssmp_message_pipes_props_i (
  .clk, .reset_n, .spi_cs_n, .spi_miso_oe, .cmd_valid, .cmd_end, .cmd_ok, .sampling_mode,
  .notif_wr_valid, .notif_wr_last, .notif_wr_ready, .meas_wr_valid, .meas_wr_last,
  .meas_wr_ready, .message_waiting_line, .message_waiting_line_oe
);

//--- tb/ssmp_host.sv
// Host master model: SPI mode 3, MSB first, pins change on clk falling edge.
// Assumes clk from the bench; half SCK period of four clk cycles.
`timescale 1ns/1ps
module ssmp_host (
  input  wire logic clk,
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  import ssmp_pkg::*;
  ssmp_byte_t wr [16];
  ssmp_byte_t rd [20];

  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b1;
    spi_mosi = 1'b1;
  end

  // ==========================================================================
  // One transfer: opcode, three fill bytes, then n data bytes
  task automatic xfer(input ssmp_byte_t op, input int n);
    ssmp_byte_t tx;
    ssmp_byte_t rx;
    @(negedge clk);
    spi_cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int b = 0; b < n + 4; b++) begin
      tx = (b == 0) ? op : (b < 4) ? 8'hFF : wr[b - 4];
      for (int i = 7; i >= 0; i--) begin
        spi_sck  = 1'b0;
        spi_mosi = tx[i];
        repeat (4) @(negedge clk);
        rx[i]   = spi_miso;
        spi_sck = 1'b1;
        repeat (4) @(negedge clk);
      end
      rd[b] = rx;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (8) @(negedge clk);
  endtask
endmodule

//--- tb/tb_top.sv
// Bench top: clock, reset, host model, pipe loaders and scenarios.
// Assumes package, design, checker and host model compiled before it.
`timescale 1ns/1ps
module tb_top;
  import ssmp_pkg::*;
  logic       clk, reset_n, ce, spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic       cmd_valid, cmd_end, cmd_ok, sampling_mode, last_ok;
  logic       message_waiting_line, message_waiting_line_oe;
  logic       notif_wr_valid, notif_wr_last, notif_wr_ready;
  logic       meas_wr_valid, meas_wr_last, meas_wr_ready;
  ssmp_byte_t cmd_byte, notif_wr_byte, meas_wr_byte;
  ssmp_byte_t cmd_q [$];
  ssmp_byte_t pb [4];
  int         n_fail, compares, n_end, cyc;

  ssmp_message_pipes ssmp_message_pipes_i (
    .clk, .reset_n, .ce, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe,
    .cmd_valid, .cmd_byte, .cmd_end, .cmd_ok, .sampling_mode,
    .notif_wr_valid, .notif_wr_byte, .notif_wr_last, .notif_wr_ready,
    .meas_wr_valid, .meas_wr_byte, .meas_wr_last, .meas_wr_ready,
    .message_waiting_line, .message_waiting_line_oe
  );
  ssmp_host ssmp_host_i (.clk, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso);

  always #20 clk = ~clk;

  // ==========================================================================
  // Command monitor and timeout
  always @(posedge clk) begin
    cyc++;
    if (cmd_valid === 1'b1) begin
      cmd_q.push_back(cmd_byte);
    end
    if (cmd_end === 1'b1) begin
      n_end++;
      last_ok = cmd_ok;
    end
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic final_report;
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic set_cfg(input ssmp_byte_t v);
    ssmp_host_i.wr[0] = v;
    ssmp_host_i.xfer(8'h02, 1);
  endtask

  task automatic load(input bit m, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      notif_wr_valid = !m;
      meas_wr_valid  = m;
      notif_wr_byte  = pb[i];
      meas_wr_byte   = pb[i];
      notif_wr_last  = (i == n - 1);
      meas_wr_last   = (i == n - 1);
    end
    @(negedge clk);
    notif_wr_valid = 1'b0;
    meas_wr_valid  = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic send_cmd(input ssmp_byte_t mid, input ssmp_byte_t cks, input logic ok,
                          input logic mode);
    ssmp_host_i.wr[0] = mid;
    ssmp_host_i.wr[1] = 8'h00;
    ssmp_host_i.wr[2] = cks;
    cmd_q.delete();
    n_end = 0;
    ssmp_host_i.xfer(8'h03, 3);
    chk("cmd_count", 16'(cmd_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      chk("cmd_byte", cmd_q[i], ssmp_host_i.wr[i]);
    end
    chk("cmd_end", 16'(n_end), 16'h0001);
    chk("cmd_ok", last_ok, ok);
    chk("mode", sampling_mode, mode);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("line", message_waiting_line, 1'b0);
    chk("line_oe", message_waiting_line_oe, 1'b1);
    chk("mode", sampling_mode, 1'b0);
    chk("meas_ready", meas_wr_ready, 1'b0);
    chk("miso_oe", spi_miso_oe, 1'b0);
  endtask

  task automatic t_hold;
    ce             = 1'b0;
    notif_wr_valid = 1'b1;
    notif_wr_last  = 1'b1;
    repeat (4) @(negedge clk);
    chk("frozen_ready", notif_wr_ready, 1'b0);
    notif_wr_valid = 1'b0;
    ce             = 1'b1;
    repeat (4) @(negedge clk);
    chk("held_ready", notif_wr_ready, 1'b1);
    chk("held_line", message_waiting_line, 1'b0);
  endtask

  task automatic t_info;
    ssmp_host_i.xfer(8'h01, 3);
    for (int i = 0; i < 4; i++) begin
      chk("header", ssmp_host_i.rd[i], (i == 0) ? 8'hFA : 8'hFF);
    end
    chk("version", ssmp_host_i.rd[4], 8'h01);
    chk("cfg", ssmp_host_i.rd[5], 8'h0C);
    chk("again", ssmp_host_i.rd[6], 8'h01);
    set_cfg(8'hF5);
    chk("idle_high", message_waiting_line, 1'b1);
    chk("pp_oe", message_waiting_line_oe, 1'b1);
    set_cfg(8'hF7);
    chk("od_oe", message_waiting_line_oe, 1'b0);
    chk("od_out", message_waiting_line, 1'b0);
    ssmp_host_i.wr[0] = 8'h0C;
    ssmp_host_i.xfer(8'h07, 1);
    chk("undef", ssmp_host_i.rd[4], 8'hFF);
    ssmp_host_i.xfer(8'h01, 2);
    chk("cfg_rd", ssmp_host_i.rd[5], 8'h07);
    set_cfg(8'h0C);
    chk("idle_low", message_waiting_line, 1'b0);
  endtask

  task automatic t_notif;
    pb = '{8'hAA, 8'h01, 8'h55, 8'h00};
    load(1'b0, 3);
    chk("notif_full", notif_wr_ready, 1'b0);
    chk("line", message_waiting_line, 1'b1);
    ssmp_host_i.xfer(8'h04, 4);
    chk("notif_size", {ssmp_host_i.rd[5], ssmp_host_i.rd[4]}, 16'h0003);
    chk("meas_size", {ssmp_host_i.rd[7], ssmp_host_i.rd[6]}, 16'h0000);
    set_cfg(8'h08);
    chk("line", message_waiting_line, 1'b0);
    set_cfg(8'h0C);
    ssmp_host_i.xfer(8'h05, 3);
    for (int i = 0; i < 3; i++) begin
      chk("notif_byte", ssmp_host_i.rd[i + 4], pb[i]);
    end
    chk("line", message_waiting_line, 1'b0);
    chk("notif_free", notif_wr_ready, 1'b1);
  endtask

  task automatic t_meas;
    pb = '{8'h11, 8'h22, 8'h33, 8'h44};
    load(1'b1, 4);
    chk("meas_full", meas_wr_ready, 1'b0);
    chk("line", message_waiting_line, 1'b1);
    set_cfg(8'h04);
    chk("line", message_waiting_line, 1'b0);
    set_cfg(8'h0C);
    ssmp_host_i.xfer(8'h04, 4);
    chk("meas_size", {ssmp_host_i.rd[7], ssmp_host_i.rd[6]}, 16'h0004);
    ssmp_host_i.xfer(8'h06, 4);
    for (int i = 0; i < 4; i++) begin
      chk("meas_byte", ssmp_host_i.rd[i + 4], pb[i]);
    end
    chk("line", message_waiting_line, 1'b0);
    send_cmd(8'h30, 8'hD1, 1'b1, 1'b0);
    chk("meas_closed", meas_wr_ready, 1'b0);
  endtask

  initial begin
    clk            = 1'b0;
    reset_n        = 1'b0;
    ce             = 1'b1;
    notif_wr_valid = 1'b0;
    notif_wr_byte  = 8'h00;
    notif_wr_last  = 1'b0;
    meas_wr_valid  = 1'b0;
    meas_wr_byte   = 8'h00;
    meas_wr_last   = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_hold();
    t_info();
    send_cmd(8'h10, 8'hF0, 1'b0, 1'b0);
    send_cmd(8'h10, 8'hF1, 1'b1, 1'b1);
    t_notif();
    t_meas();
    final_report();
  end
endmodule
